// [sim/dcfp_mem_model.sv]
// memory-side responder: termination, burst acknowledge, inhibit and bus error beats
module dcfp_mem_model (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       go,
	input  wire logic       inh_all,
	input  wire logic [2:0] nb,
	input  wire logic [2:0] err_at,
	input  wire logic [2:0] last_ph,
	output logic            sync_term_in,
	output logic            burst_ack_in,
	output logic            cache_inhibit_in,
	output logic            bus_err_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] ph_ff;
	logic [2:0] k_ff;
	logic       run_ff;
	logic       tog_ff;
	logic       beat;
	////////////////////////////////////////
	// beat sequencer, last_ph sets the low gap between beats
	always_ff @(posedge aclk)
	begin
		if (!aresetn || go)
		begin
			run_ff <= aresetn & go;
			ph_ff  <= 3'h2;
			k_ff   <= 3'h0;
		end
		else if (run_ff)
		begin
			if (ph_ff >= last_ph)
			begin
				run_ff <= (k_ff != nb);
				ph_ff  <= 3'h0;
			end
			else
				ph_ff <= ph_ff + 3'h1;
			if (ph_ff == 3'h1)
				k_ff <= k_ff + 3'h1;
		end
	end
	// released lines change every cycle
	always_ff @(posedge aclk)
	begin
		tog_ff <= aresetn & ~tog_ff;
	end
	////////////////////////////////////////
	assign beat             = run_ff && (ph_ff < 3'h2);
	assign sync_term_in     = beat && (k_ff != err_at);
	assign bus_err_in       = beat && (k_ff == err_at);
	assign cache_inhibit_in = beat ? inh_all : tog_ff;
	assign burst_ack_in     = beat | ~tog_ff;
endmodule

// [sim/test_dcfp_top.sv]
// self-checking bench for the cache fill policy block
module test_dcfp_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] B1 = 32'h1;
	localparam logic [31:0] DC = (B1 << dcfp_pkg::CTRL_DEN) | (B1 << dcfp_pkg::CTRL_DBE);
	localparam logic [31:0] AL = B1 << dcfp_pkg::CTRL_ALC;
	localparam logic [31:0] IC = (B1 << dcfp_pkg::CTRL_IEN) | (B1 << dcfp_pkg::CTRL_IBE);
	localparam logic [31:0] OK = {30'h0, dcfp_pkg::RESP_OKAY};
	localparam logic [1:0]  LG = dcfp_pkg::SZ_LONG;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	logic [31:0] ifetch_addr = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, acc_valid = 1'b0, ifetch_use = 1'b0;
	dcfp_pkg::dcfp_acc_t acc_req = '0;
	logic m_go = 1'b0, m_inh = 1'b0;
	logic [2:0] m_nb = 3'h0, m_err = 3'h7, m_ph = 3'h4;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, upd_word_ff, rw;
	logic [31:0] s_axi_rdata, r_upd, rd, rs;
	logic acc_busy_ff, acc_done_ff, acc_hit_ff, burst_req_ff, cache_upd_ff;
	logic data_exc_ff, instr_exc_ff, fill_abort_ff, r_hit, r_bst, r_ab, r_dx, r_ix;
	logic sync_term_in, burst_ack_in, cache_inhibit_in, bus_err_in;
	int error_cnt = 0, n_tests = 0;
	always #25 aclk = ~aclk;
	dcfp_top u_dcfp_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .acc_valid, .acc_req, .ifetch_use,
		.ifetch_addr, .sync_term_in, .burst_ack_in, .cache_inhibit_in, .bus_err_in,
		.acc_busy_ff, .acc_done_ff, .acc_hit_ff, .burst_req_ff, .cache_upd_ff, .upd_word_ff,
		.data_exc_ff, .instr_exc_ff, .fill_abort_ff);
	dcfp_mem_model u_dcfp_mem_model (.aclk, .aresetn, .go(m_go), .inh_all(m_inh), .nb(m_nb),
		.err_at(m_err), .last_ph(m_ph), .sync_term_in, .burst_ack_in, .cache_inhibit_in,
		.bus_err_in);
	////////////////////////////////////////
	task test_done;
		if (error_cnt == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task tmo;
		error_cnt++;
		test_done;
	endtask
	task axw(input logic [31:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1)
			begin
				rs = {30'h0, s_axi_bresp};
				s_axi_bready <= 1'b0;
				return;
			end
		end
		tmo;
	endtask
	task axr(input logic [31:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1)
			begin
				rd = s_axi_rdata;
				rs = {30'h0, s_axi_rresp};
				s_axi_rready <= 1'b0;
				return;
			end
		end
		tmo;
	endtask
	task setc(input logic [31:0] v);
		axw(dcfp_pkg::OFF_CTRL, v);
		chk(rs, OK);
	endtask
	// one access, beats nb supplied by the memory model, flags gathered until done
	task acc(input logic ic, w, c, input logic [1:0] sz, input logic [31:0] a,
		input logic [2:0] nb);
		@(posedge aclk);
		{r_hit, r_bst, r_ab, r_dx, r_ix} = 5'h0;
		r_upd = 32'h0;
		acc_req <= '{ic, w, c, sz, a};
		acc_valid <= 1'b1;
		m_nb <= nb;
		m_go <= (nb != 3'h0);
		@(posedge aclk);
		acc_valid <= 1'b0;
		m_go <= 1'b0;
		for (int n = 0; n < 300; n++)
		begin
			@(posedge aclk);
			{r_hit, r_bst, r_ab} = {r_hit | acc_hit_ff, r_bst | burst_req_ff, r_ab | fill_abort_ff};
			{r_dx, r_ix} = {r_dx | data_exc_ff, r_ix | instr_exc_ff};
			r_upd = r_upd + {31'h0, cache_upd_ff};
			if (cache_upd_ff === 1'b1)
				rw = upd_word_ff;
			if (acc_done_ff === 1'b1)
			begin
				chk({31'h0, acc_busy_ff}, 32'h1);
				return;
			end
		end
		tmo;
	endtask
	task res(input logic h, b, ab, dx, input logic [31:0] u);
		chk({27'h0, r_hit, r_bst, r_ab, r_dx, r_ix}, {27'h0, h, b, ab, dx, 1'b0});
		chk(r_upd, u);
	endtask
	task ifu(input logic [31:0] a, input logic e);
		@(posedge aclk);
		ifetch_addr <= a;
		ifetch_use <= 1'b1;
		@(posedge aclk);
		ifetch_use <= 1'b0;
		r_ix = 1'b0;
		repeat (8)
		begin
			@(posedge aclk);
			r_ix = r_ix | instr_exc_ff;
		end
		chk({31'h0, r_ix}, {31'h0, e});
	endtask
	////////////////////////////////////////
	task t_regs;
		axr(dcfp_pkg::OFF_CTRL);
		chk(rd, {27'h0, dcfp_pkg::CTRL_RST});
		setc(DC | AL);
		axr(dcfp_pkg::OFF_CTRL);
		chk(rd, DC | AL);
		s_axi_wstrb <= 4'h0;
		setc(32'h0000_0000);
		s_axi_wstrb <= 4'hF;
		axr(dcfp_pkg::OFF_CTRL);
		chk(rd, DC | AL);
		axr(32'h0000_0100);
		chk(rs, {30'h0, dcfp_pkg::RESP_SLVERR});
		axw(dcfp_pkg::OFF_STAT, 32'h0000_00FF);
		chk(rs, OK);
	endtask
	task t_fill;
		setc(DC);
		acc(1'b0, 1'b0, 1'b1, LG, 32'h0000_1044, 3'h4);
		res(1'b0, 1'b1, 1'b0, 1'b0, 32'h4);
		acc(1'b0, 1'b0, 1'b1, LG, 32'h0000_104C, 3'h0);
		res(1'b1, 1'b0, 1'b0, 1'b0, 32'h0);
		acc(1'b0, 1'b1, 1'b1, LG, 32'h0000_1048, 3'h0);
		res(1'b1, 1'b0, 1'b0, 1'b0, 32'h1);
		setc(B1 << dcfp_pkg::CTRL_DEN);
		acc(1'b0, 1'b0, 1'b1, LG, 32'h0000_2058, 3'h1);
		res(1'b0, 1'b0, 1'b0, 1'b0, 32'h1);
		chk({30'h0, rw}, 32'h2);
		setc(B1 << dcfp_pkg::CTRL_DBE);
		acc(1'b0, 1'b0, 1'b1, LG, 32'h0000_2068, 3'h1);
		res(1'b0, 1'b0, 1'b0, 1'b0, 32'h0);
	endtask
	task t_inh;
		setc(DC);
		m_inh <= 1'b1;
		acc(1'b0, 1'b0, 1'b1, LG, 32'h0000_3060, 3'h1);
		res(1'b0, 1'b1, 1'b1, 1'b0, 32'h0);
		m_inh <= 1'b0;
		m_ph <= 3'h7;
		acc(1'b0, 1'b0, 1'b1, LG, 32'h0000_3060, 3'h4);
		res(1'b0, 1'b1, 1'b0, 1'b0, 32'h4);
		m_ph <= 3'h4;
		acc(1'b0, 1'b1, 1'b1, LG, 32'h0000_4070, 3'h0);
		res(1'b0, 1'b0, 1'b0, 1'b0, 32'h0);
		acc(1'b0, 1'b0, 1'b1, LG, 32'h0000_4070, 3'h4);
		res(1'b0, 1'b1, 1'b0, 1'b0, 32'h4);
	endtask
	task t_wa;
		setc(DC | AL);
		acc(1'b0, 1'b1, 1'b1, LG, 32'h0000_5080, 3'h0);
		res(1'b0, 1'b0, 1'b0, 1'b0, 32'h1);
		acc(1'b0, 1'b0, 1'b1, LG, 32'h0000_5080, 3'h0);
		res(1'b1, 1'b0, 1'b0, 1'b0, 32'h0);
		acc(1'b0, 1'b0, 1'b1, LG, 32'h0000_5084, 3'h1);
		res(1'b0, 1'b0, 1'b0, 1'b0, 32'h1);
		acc(1'b0, 1'b1, 1'b1, dcfp_pkg::SZ_BYTE, 32'h0000_6094, 3'h0);
		res(1'b0, 1'b0, 1'b0, 1'b0, 32'h0);
		acc(1'b0, 1'b1, 1'b1, dcfp_pkg::SZ_WORD, 32'h0000_7086, 3'h0);
		res(1'b0, 1'b0, 1'b0, 1'b0, 32'h0);
		acc(1'b0, 1'b0, 1'b1, LG, 32'h0000_5084, 3'h1);
		res(1'b0, 1'b0, 1'b0, 1'b0, 32'h1);
		acc(1'b0, 1'b1, 1'b0, LG, 32'h0000_5088, 3'h0);
		res(1'b0, 1'b0, 1'b0, 1'b0, 32'h0);
	endtask
	task t_err;
		setc(DC | IC);
		m_err <= 3'h0;
		acc(1'b0, 1'b0, 1'b1, LG, 32'h0000_70A0, 3'h1);
		res(1'b0, 1'b1, 1'b1, 1'b1, 32'h0);
		m_err <= 3'h2;
		acc(1'b0, 1'b0, 1'b1, LG, 32'h0000_80B0, 3'h3);
		res(1'b0, 1'b1, 1'b1, 1'b0, 32'h2);
		m_err <= 3'h1;
		acc(1'b1, 1'b0, 1'b1, LG, 32'h0000_90C0, 3'h2);
		res(1'b0, 1'b1, 1'b1, 1'b0, 32'h1);
		m_err <= 3'h7;
		acc(1'b0, 1'b0, 1'b1, LG, 32'h0000_80B8, 3'h1);
		res(1'b0, 1'b0, 1'b0, 1'b0, 32'h1);
		acc(1'b0, 1'b0, 1'b1, LG, 32'h0000_70A0, 3'h4);
		res(1'b0, 1'b1, 1'b0, 1'b0, 32'h4);
		ifu(32'h0000_90C0, 1'b0);
		ifu(32'h0000_90C4, 1'b1);
	endtask
	////////////////////////////////////////
	initial
	begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs;
		t_fill;
		t_inh;
		t_wa;
		t_err;
		test_done;
	end
endmodule

// [src/dcfp_pkg.sv]
// constants, types and states for the cache fill policy block
package dcfp_pkg;

	localparam int unsigned WORDS     = 4;
	localparam int unsigned TAG_W     = 24;
	localparam int unsigned MEM_AW    = 5;
	localparam int unsigned MEM_DEPTH = 32;
	localparam int unsigned TAG_LSB   = 8;
	localparam int unsigned IDX_LSB   = 4;
	localparam int unsigned WORD_LSB  = 2;

	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	localparam logic [1:0] SZ_LONG = 2'h2;

	localparam logic [31:0] OFF_CTRL = 32'h0000_0000;
	localparam logic [31:0] OFF_STAT = 32'h0000_0004;

	localparam int unsigned CTRL_IEN = 0;
	localparam int unsigned CTRL_IBE = 1;
	localparam int unsigned CTRL_DEN = 2;
	localparam int unsigned CTRL_DBE = 3;
	localparam int unsigned CTRL_ALC = 4;
	localparam logic [4:0]  CTRL_RST = 5'h00;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] BEAT_LAST   = 2'h3;

	typedef struct packed {
		logic        icache;
		logic        write;
		logic        cachable;
		logic [1:0]  size;
		logic [31:0] addr;
	} dcfp_acc_t;

	typedef struct packed {
		logic [TAG_W-1:0] tag;
		logic [WORDS-1:0] valid;
	} dcfp_ent_t;

	typedef struct packed {
		logic term;
		logic back;
		logic inh;
		logic berr;
	} dcfp_pins_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_LOOK = 2'h1,
		ST_FILL = 2'h3,
		ST_DONE = 2'h2
	} dcfp_state_t;

endpackage

// [src/dcfp_tag_mem.sv]
// tag and valid store for both caches, registered read
module dcfp_tag_mem (
	input  wire logic                           aclk,
	input  wire logic                           aresetn,
	input  wire logic [dcfp_pkg::MEM_AW-1:0]    rd_addr,
	output dcfp_pkg::dcfp_ent_t                 rd_data_ff,
	input  wire logic                           wr_en,
	input  wire logic [dcfp_pkg::MEM_AW-1:0]    wr_addr,
	input  wire dcfp_pkg::dcfp_ent_t            wr_data
);

	dcfp_pkg::dcfp_ent_t mem_ff [dcfp_pkg::MEM_DEPTH];

	// all lines invalid after reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < dcfp_pkg::MEM_DEPTH; i++)
				mem_ff[i] <= '0;
		end
		else if (wr_en)
			mem_ff[wr_addr] <= wr_data;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rd_data_ff <= '0;
		else
			rd_data_ff <= mem_ff[rd_addr];
	end

endmodule

// [src/dcfp_top.sv]
// fill and update policy for the instruction and data cache pair
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
module dcfp_top (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic [31:0]          s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [31:0]          s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire logic                 acc_valid,
	input  wire dcfp_pkg::dcfp_acc_t  acc_req,
	input  wire logic                 ifetch_use,
	input  wire logic [31:0]          ifetch_addr,
	input  wire logic                 sync_term_in,
	input  wire logic                 burst_ack_in,
	input  wire logic                 cache_inhibit_in,
	input  wire logic                 bus_err_in,
	output logic                      acc_busy_ff,
	output logic                      acc_done_ff,
	output logic                      acc_hit_ff,
	output logic                      burst_req_ff,
	output logic                      cache_upd_ff,
	output logic [1:0]                upd_word_ff,
	output logic                      data_exc_ff,
	output logic                      instr_exc_ff,
	output logic                      fill_abort_ff
);

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [3:0] word_mask(input logic [31:0] a, input logic [1:0] sz);
		logic [2:0] nb;
		logic [3:0] m;
		nb = (sz == dcfp_pkg::SZ_BYTE) ? 3'h1 : (sz == dcfp_pkg::SZ_WORD) ? 3'h2 : 3'h4;
		m = 4'h1 << a[3:2];
		if ((({1'b0, a[1:0]} + nb) > 3'h4) && (a[3:2] != 2'h3))
			m = m | (4'h2 << a[3:2]);
		return m;
	endfunction

	function automatic logic aligned_long(input logic [31:0] a, input logic [1:0] sz);
		return (sz == dcfp_pkg::SZ_LONG) && (a[1:0] == 2'h0);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// state

	dcfp_pkg::dcfp_state_t state_ff;
	dcfp_pkg::dcfp_state_t nxt_state;
	dcfp_pkg::dcfp_acc_t   req_ff;
	dcfp_pkg::dcfp_ent_t   ent;
	dcfp_pkg::dcfp_ent_t   fill_ent_ff;
	dcfp_pkg::dcfp_ent_t   mem_wd;
	dcfp_pkg::dcfp_pins_t  pin_meta_ff;
	dcfp_pkg::dcfp_pins_t  pin_sync_ff;
	dcfp_pkg::dcfp_pins_t  pin_prev_ff;
	logic [4:0]            ctrl_ff;
	logic [1:0]            fill_word_ff;
	logic [1:0]            beat_cnt_ff;
	logic                  fill_on_ff;
	logic                  ierr_valid_ff;
	logic [29:0]           ierr_addr_ff;
	logic                  mem_we;
	logic                  tag_eq;
	logic                  alloc_on;
	logic                  cache_on;
	logic                  burst_on;
	logic                  beat;
	logic                  berr_beat;
	logic                  ev_upd;
	logic                  ev_hit;
	logic                  ev_exc;
	logic                  ev_abort;
	logic                  ev_ierr;
	logic                  ev_start;
	logic                  ev_burst;
	logic                  ev_step;
	logic [1:0]            ev_word;
	logic [3:0]            mask;

	dcfp_tag_mem u_tag_mem (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.rd_addr    ({acc_req.icache, acc_req.addr[7:4]}),
		.rd_data_ff (ent),
		.wr_en      (mem_we),
		.wr_addr    ({req_ff.icache, req_ff.addr[7:4]}),
		.wr_data    (mem_wd)
	);

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and beat detection

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_meta_ff <= '0;
			pin_sync_ff <= '0;
			pin_prev_ff <= '0;
		end
		else
		begin
			pin_meta_ff <= {sync_term_in, burst_ack_in, cache_inhibit_in, bus_err_in};
			pin_sync_ff <= pin_meta_ff;
			pin_prev_ff <= pin_sync_ff;
		end
	end

	assign berr_beat = pin_sync_ff.berr && !pin_prev_ff.berr;
	assign beat      = berr_beat || (pin_sync_ff.term && !pin_prev_ff.term);

	////////////////////////////////////////////////////////////////////////////////
	// policy decisions

	always_comb
	begin
		nxt_state = state_ff;
		mem_we    = 1'b0;
		mem_wd    = fill_ent_ff;
		ev_upd    = 1'b0;
		ev_hit    = 1'b0;
		ev_exc    = 1'b0;
		ev_abort  = 1'b0;
		ev_ierr   = 1'b0;
		ev_start  = 1'b0;
		ev_burst  = 1'b0;
		ev_step   = 1'b0;
		ev_word   = req_ff.addr[3:2];
		tag_eq    = ent.tag == req_ff.addr[31:8];
		alloc_on  = ctrl_ff[dcfp_pkg::CTRL_ALC];
		mask      = word_mask(req_ff.addr, req_ff.size);
		cache_on  = req_ff.icache ? ctrl_ff[dcfp_pkg::CTRL_IEN] : ctrl_ff[dcfp_pkg::CTRL_DEN];
		burst_on  = cache_on && (req_ff.icache ? ctrl_ff[dcfp_pkg::CTRL_IBE]
			: ctrl_ff[dcfp_pkg::CTRL_DBE]);
		case (state_ff)
			dcfp_pkg::ST_IDLE:
			begin
				if (acc_valid)
					nxt_state = dcfp_pkg::ST_LOOK;
			end
			dcfp_pkg::ST_LOOK:
			begin
				nxt_state = dcfp_pkg::ST_DONE;
				if (req_ff.write)
				begin
					// inhibit pin is not consulted on writes
					ev_hit = tag_eq && ent.valid[req_ff.addr[3:2]] && cache_on;
					if (cache_on && !req_ff.icache && req_ff.cachable)
					begin
						if (ev_hit)
							ev_upd = 1'b1;
						else if (alloc_on && aligned_long(req_ff.addr, req_ff.size))
						begin
							mem_we = 1'b1;
							mem_wd.tag = req_ff.addr[31:8];
							mem_wd.valid = (tag_eq ? ent.valid : 4'h0) | mask;
							ev_upd = 1'b1;
						end
						else if (alloc_on)
						begin
							mem_we = 1'b1;
							mem_wd.tag = ent.tag;
							mem_wd.valid = ent.valid & ~mask;
						end
					end
				end
				else if (tag_eq && ent.valid[req_ff.addr[3:2]] && cache_on)
					ev_hit = 1'b1;
				else
				begin
					nxt_state = dcfp_pkg::ST_FILL;
					ev_start = 1'b1;
					ev_burst = burst_on && (!tag_eq || (ent.valid == 4'h0));
				end
			end
			dcfp_pkg::ST_FILL:
			begin
				ev_word = fill_word_ff;
				if (beat && berr_beat)
				begin
					mem_we = fill_on_ff;
					mem_wd.valid[fill_word_ff] = 1'b0;
					ev_abort = 1'b1;
					ev_exc = (beat_cnt_ff == 2'h0) && !req_ff.icache;
					ev_ierr = req_ff.icache;
					nxt_state = dcfp_pkg::ST_DONE;
				end
				else if (beat)
				begin
					if (!pin_sync_ff.inh && fill_on_ff)
					begin
						mem_we = 1'b1;
						mem_wd.valid[fill_word_ff] = 1'b1;
						ev_upd = 1'b1;
					end
					ev_abort = pin_sync_ff.inh;
					if (pin_sync_ff.inh || !burst_req_ff || !pin_sync_ff.back
						|| (beat_cnt_ff == dcfp_pkg::BEAT_LAST))
						nxt_state = dcfp_pkg::ST_DONE;
					else
						ev_step = 1'b1;
				end
			end
			dcfp_pkg::ST_DONE:
				nxt_state = dcfp_pkg::ST_IDLE;
			default:
				nxt_state = dcfp_pkg::ST_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// sequencing

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_ff <= dcfp_pkg::ST_IDLE;
			req_ff <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
			if (state_ff == dcfp_pkg::ST_IDLE && acc_valid)
				req_ff <= acc_req;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fill_ent_ff <= '0;
			fill_word_ff <= 2'h0;
			beat_cnt_ff <= 2'h0;
			fill_on_ff <= 1'b0;
			burst_req_ff <= 1'b0;
		end
		else
		begin
			if (ev_start)
			begin
				fill_ent_ff.tag <= req_ff.addr[31:8];
				fill_ent_ff.valid <= tag_eq ? ent.valid : 4'h0;
				fill_word_ff <= req_ff.addr[3:2];
				beat_cnt_ff <= 2'h0;
				fill_on_ff <= cache_on;
			end
			else if (state_ff == dcfp_pkg::ST_FILL && mem_we)
				fill_ent_ff <= mem_wd;
			if (ev_step)
			begin
				fill_word_ff <= fill_word_ff + 2'h1;
				beat_cnt_ff <= beat_cnt_ff + 2'h1;
			end
			if (ev_burst)
				burst_req_ff <= 1'b1;
			else if (nxt_state == dcfp_pkg::ST_DONE)
				burst_req_ff <= 1'b0;
		end
	end

	// pending instruction fault, raised only when the bad word is fetched
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ierr_valid_ff <= 1'b0;
			ierr_addr_ff <= '0;
			instr_exc_ff <= 1'b0;
		end
		else
		begin
			instr_exc_ff <= ifetch_use && ierr_valid_ff && (ifetch_addr[31:2] == ierr_addr_ff);
			if (ev_ierr)
			begin
				ierr_valid_ff <= 1'b1;
				ierr_addr_ff <= {req_ff.addr[31:4], fill_word_ff};
			end
			else if (ifetch_use && ifetch_addr[31:2] == ierr_addr_ff)
				ierr_valid_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			acc_busy_ff <= 1'b0;
			acc_done_ff <= 1'b0;
			acc_hit_ff <= 1'b0;
			cache_upd_ff <= 1'b0;
			upd_word_ff <= 2'h0;
			data_exc_ff <= 1'b0;
			fill_abort_ff <= 1'b0;
		end
		else
		begin
			acc_busy_ff <= nxt_state != dcfp_pkg::ST_IDLE;
			acc_done_ff <= nxt_state == dcfp_pkg::ST_DONE;
			acc_hit_ff <= ev_hit;
			cache_upd_ff <= ev_upd;
			upd_word_ff <= ev_word;
			data_exc_ff <= ev_exc;
			fill_abort_ff <= ev_abort;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register slave

	logic        aw_got_ff;
	logic        w_got_ff;
	logic [31:0] aw_addr_ff;
	logic [31:0] w_data_ff;
	logic        w_lane0_ff;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= dcfp_pkg::RESP_OKAY;
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			aw_addr_ff <= '0;
			w_data_ff <= '0;
			w_lane0_ff <= 1'b0;
			ctrl_ff <= dcfp_pkg::CTRL_RST;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				s_axi_awready <= 1'b0;
				aw_got_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end
			else if (!aw_got_ff && !s_axi_bvalid)
				s_axi_awready <= 1'b1;
			if (s_axi_wvalid && s_axi_wready)
			begin
				s_axi_wready <= 1'b0;
				w_got_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_lane0_ff <= s_axi_wstrb[0];
			end
			else if (!w_got_ff && !s_axi_bvalid)
				s_axi_wready <= 1'b1;
			if (aw_got_ff && w_got_ff && !s_axi_bvalid)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= dcfp_pkg::RESP_OKAY;
				if (aw_addr_ff[31:2] == dcfp_pkg::OFF_CTRL[31:2])
				begin
					if (w_lane0_ff)
						ctrl_ff <= w_data_ff[4:0];
				end
				else if (aw_addr_ff[31:2] != dcfp_pkg::OFF_STAT[31:2])
					s_axi_bresp <= dcfp_pkg::RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= dcfp_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= dcfp_pkg::RESP_OKAY;
			s_axi_rdata <= '0;
			if (s_axi_araddr[31:2] == dcfp_pkg::OFF_CTRL[31:2])
				s_axi_rdata <= {27'h0000000, ctrl_ff};
			else if (s_axi_araddr[31:2] == dcfp_pkg::OFF_STAT[31:2])
				s_axi_rdata <= {24'h000000, fill_word_ff, beat_cnt_ff, ierr_valid_ff,
					burst_req_ff, state_ff};
			else
				s_axi_rresp <= dcfp_pkg::RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
		else if (!s_axi_rvalid)
			s_axi_arready <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	a_noalloc_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_ff == dcfp_pkg::ST_LOOK && req_ff.write && !ctrl_ff[dcfp_pkg::CTRL_ALC]) |-> !mem_we)
		else $error("write with allocation off changed the tag store");
	a_alloc_new_tag: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_ff == dcfp_pkg::ST_LOOK && req_ff.write && alloc_on && cache_on && !req_ff.icache
		&& req_ff.cachable && !tag_eq && aligned_long(req_ff.addr, req_ff.size))
		|-> (mem_we && mem_wd.tag == req_ff.addr[31:8]
		&& mem_wd.valid == word_mask(req_ff.addr, req_ff.size)))
		else $error("aligned long miss did not allocate one valid word");
	a_partial_keep_tag: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_ff == dcfp_pkg::ST_LOOK && req_ff.write && alloc_on && cache_on && !req_ff.icache
		&& req_ff.cachable && !tag_eq && !aligned_long(req_ff.addr, req_ff.size))
		|-> (mem_wd.tag == ent.tag && (mem_wd.valid & mask) == 4'h0) ##1 !cache_upd_ff)
		else $error("partial write miss altered tag or data");
	a_write_hit_upd: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_ff == dcfp_pkg::ST_LOOK && req_ff.write && !req_ff.icache && req_ff.cachable
		&& cache_on && tag_eq && ent.valid[req_ff.addr[3:2]]) |=> (cache_upd_ff && acc_hit_ff))
		else $error("cachable write hit not updated");
	a_inhibit_no_fill: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_ff == dcfp_pkg::ST_FILL && beat && !berr_beat && pin_sync_ff.inh)
		|=> (!cache_upd_ff && fill_abort_ff && !burst_req_ff && state_ff == dcfp_pkg::ST_DONE))
		else $error("inhibited beat updated cache or burst went on");
	a_operand_berr: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_ff == dcfp_pkg::ST_FILL && berr_beat && beat_cnt_ff == 2'h0 && !req_ff.icache)
		|=> data_exc_ff ##1 !data_exc_ff)
		else $error("operand bus error raised no exception");
	a_fill_berr_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_ff == dcfp_pkg::ST_FILL && berr_beat && beat_cnt_ff != 2'h0)
		|-> (!mem_wd.valid[fill_word_ff] && mem_we == fill_on_ff) ##1 (!data_exc_ff && fill_abort_ff))
		else $error("non-operand bus error mishandled");
	a_ifetch_fault: assert property (@(posedge aclk) disable iff (!aresetn)
		instr_exc_ff |-> ($past(ierr_valid_ff) && $past(ifetch_use)))
		else $error("instruction fault without pending error");
	a_burst_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(burst_req_ff) |-> ($past(burst_on) && $past(state_ff) == dcfp_pkg::ST_LOOK))
		else $error("burst requested while not permitted");
	a_burst_length: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_ff == dcfp_pkg::ST_FILL && beat && beat_cnt_ff == dcfp_pkg::BEAT_LAST)
		|=> state_ff == dcfp_pkg::ST_DONE)
		else $error("burst ran beyond four long words");

endmodule
